// [hdl/drive_input_mode_logic.sv]
// Input-mode logic: preset-position and bipolar modes, AXI4-Lite registers
// Behaviour
// - In-motion set when error above band or speed above zero-speed setpoint.
// - At-position set when error and speed below limits; cleared by trigger.
// - Select code 0 home, 1-6 absolute, 7-14 incremental, 15 reset.
// - Each target uses the preset speed with the same index.
// - Group select high picks accel group two, low group one.
// - Absolute move goes to target measured from home as zero.
// - Incremental move adds the preset amount to present position.
// - Code 15 with trigger clears fault and zeroes position counter.
// - Home move runs forward to reference then to offset position.
// - Trigger pulse starts a move by changing the position target.
// - Dropping a direction enable aborts; re-enable and retrigger to resume. Code aborts only when both enables are dropped.
// - Homing seeks index in speed mode, then positions to index plus offset.
// - Offset positioning uses preset speed one and accel group one.
// - Homing during a move ramps to homing speed in group one.
// - Homing may be retriggered while already at home.
// - Bipolar: dropping drive enable disables control at once, coasting.
// - Dropping one direction enable stops that direction only.
// - Both direction enables dropped decelerate motor to stop.
// - Bipolar homing runs at homing speed to index, then preset one. Code keeps homing speed while select A is high and has no index step.
// - Torque select gives torque mode in vector only, else speed mode.
// - Two table inputs select among four tables in binary order.
// - Bipolar fault reset pulse clears active fault.
// - With trip enabled, low trip input raises external trip.
// - Operating mode changes only while drive disabled; kept outside tables.
// - Table switch honoured only if mode supports switching. Code also switches tables whenever the drive is disabled.
// - Active table index 0 is the first table, 1 the second.
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module drive_input_mode_logic
  import drive_input_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic drive_enable_input,
  input wire logic forward_enable_input,
  input wire logic reverse_enable_input,
  input wire logic select_input_a,
  input wire logic select_input_b,
  input wire logic select_input_c,
  input wire logic select_input_d,
  input wire logic group_or_reset_input,
  input wire logic trigger_or_trip_input,
  input wire logic index_pulse,
  input wire logic fault_in,
  input wire logic [31:0] encoder_position,
  input wire logic [31:0] motor_speed,
  input wire logic [15:0] bipolar_reference,
  output motion_cmd_t motion_cmd,
  output logic in_motion,
  output logic at_position,
  output logic fault_active,
  output logic ext_trip,
  output logic clear_position,
  output logic [1:0] active_table_index
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [9:0] pin_s1_r;
  logic [9:0] pin_s2_r;
  logic trig_d_r;
  // Two flops per opto input; first stage read by second only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 10'h000;
      pin_s2_r <= 10'h000;
      trig_d_r <= 1'b0;
    end else begin
      pin_s1_r <= {index_pulse, trigger_or_trip_input, group_or_reset_input, select_input_d,
                   select_input_c, select_input_b, select_input_a, reverse_enable_input,
                   forward_enable_input, drive_enable_input};
      pin_s2_r <= pin_s1_r;
      trig_d_r <= pin_s2_r[8];
    end
  end

  logic drv_en, fwd_en, rev_en, grp_in, trg_in, idx_in;
  logic [3:0] sel;
  logic trig_pulse;
  logic idx_d_r;
  assign drv_en = pin_s2_r[0];
  assign fwd_en = pin_s2_r[1];
  assign rev_en = pin_s2_r[2];
  assign sel = pin_s2_r[6:3];
  assign grp_in = pin_s2_r[7];
  assign trg_in = pin_s2_r[8];
  assign idx_in = pin_s2_r[9];
  assign trig_pulse = trg_in && !trig_d_r;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [3:0] ctrl_r;
  logic [31:0] band_r, zspd_r, hofs_r, target_r;
  logic [15:0] hspd_r;
  logic [31:0] preset_r [0:15];
  logic [3:0] mode_latch_r;
  logic bipolar, vector_mode, trip_en, tbl_sw_ok;
  assign bipolar = mode_latch_r[CTRL_BIPOLAR_BIT];
  assign vector_mode = mode_latch_r[CTRL_VECTOR_BIT];
  assign trip_en = mode_latch_r[CTRL_TRIPEN_BIT];
  assign tbl_sw_ok = mode_latch_r[CTRL_TBLSW_BIT];

  // AXI write channel: address and data taken in either order
  logic aw_hold_r, w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic do_write;
  assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
      end
      if (do_write) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r <= HSPD_OFS && awaddr_r[1:0] == 2'b00) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_hold_r;
  assign s_axi_wready = !w_hold_r;

  // Register stores; strobes ignored below a full word for simplicity
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      band_r <= BAND_RST;
      zspd_r <= ZSPD_RST;
      hofs_r <= HOFS_RST;
      hspd_r <= HSPD_RST;
    end else if (do_write && s_axi_wstrb != 4'h0) begin
      unique case (awaddr_r)
        CTRL_OFS: ctrl_r <= wdata_r[3:0];
        BAND_OFS: band_r <= wdata_r;
        ZSPD_OFS: zspd_r <= wdata_r;
        HOFS_OFS: hofs_r <= wdata_r;
        HSPD_OFS: hspd_r <= wdata_r[15:0];
        default: ;
      endcase
    end
  end

  // Preset table: one word per select code (speeds in the upper half)
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_preset
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          preset_r[gi] <= 32'h0000_0000;
        end else if (do_write && awaddr_r == PRESET_OFS + 8'(gi * 4)) begin
          preset_r[gi] <= wdata_r;
        end
      end
    end
  endgenerate

  // Mode is only taken up while the drive is disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_latch_r <= CTRL_RST;
    end else if (!drv_en) begin
      mode_latch_r <= ctrl_r;
    end
  end

  // Read channel; preset index counted from the start of the preset table
  logic [7:0] rd_preset_ofs;
  assign rd_preset_ofs = s_axi_araddr - PRESET_OFS;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      if (s_axi_araddr >= PRESET_OFS && s_axi_araddr < HSPD_OFS) begin
        s_axi_rdata <= preset_r[rd_preset_ofs[5:2]];
      end else begin
        unique case (s_axi_araddr)
          CTRL_OFS: s_axi_rdata <= {28'h000_0000, ctrl_r};
          BAND_OFS: s_axi_rdata <= band_r;
          ZSPD_OFS: s_axi_rdata <= zspd_r;
          HOFS_OFS: s_axi_rdata <= hofs_r;
          POSN_OFS: s_axi_rdata <= encoder_position;
          SPEED_OFS: s_axi_rdata <= motor_speed;
          STAT_OFS: s_axi_rdata <= {24'h00_0000, active_table_index, clear_position,
                                    ext_trip, fault_active, at_position, in_motion,
                                    motion_cmd.run};
          TGT_OFS: s_axi_rdata <= target_r;
          HSPD_OFS: s_axi_rdata <= {16'h0000, hspd_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // ----------------------------------------
  // Motion sequencer
  // ----------------------------------------
  move_state_t state_r;
  logic [31:0] pos_err, abs_err, abs_spd;
  logic near_done;
  logic [15:0] move_speed_r;
  logic [1:0] move_group_r;
  assign pos_err = target_r - encoder_position;
  assign abs_err = pos_err[31] ? 32'(-pos_err) : pos_err;
  assign abs_spd = motor_speed[31] ? 32'(-motor_speed) : motor_speed;
  assign near_done = (abs_err < band_r) && (abs_spd < zspd_r);
  logic both_off;
  assign both_off = !fwd_en && !rev_en;

  // Sequencer; direction enables gate the start and abort a move
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= IDLE_S;
      target_r <= 32'h0000_0000;
      move_speed_r <= 16'h0000;
      move_group_r <= GROUP_ONE;
      clear_position <= 1'b0;
      idx_d_r <= 1'b0;
    end else begin
      clear_position <= 1'b0;
      idx_d_r <= idx_in;
      if (bipolar || !drv_en || both_off) begin
        state_r <= IDLE_S;
      end else if (trig_pulse) begin
        if (sel == SEL_RESET) begin
          clear_position <= 1'b1;
          target_r <= 32'h0000_0000;
          state_r <= IDLE_S;
        end else if (sel == SEL_HOME) begin
          state_r <= HOME_SEEK_S;
          move_speed_r <= hspd_r;
          move_group_r <= GROUP_ONE;
        end else begin
          // Absolute targets measured from home; incremental from here
          target_r <= (sel <= SEL_ABS_LAST) ? preset_r[sel]
                    : encoder_position + preset_r[sel];
          move_speed_r <= preset_r[sel][31:16];
          move_group_r <= grp_in ? GROUP_TWO : GROUP_ONE;
          state_r <= MOVE_S;
        end
      end else if (state_r == HOME_SEEK_S && idx_in && !idx_d_r) begin
        target_r <= encoder_position + hofs_r;
        move_speed_r <= preset_r[1][31:16];
        move_group_r <= GROUP_ONE;
        state_r <= HOME_POS_S;
      end else if ((state_r == MOVE_S || state_r == HOME_POS_S) && near_done) begin
        state_r <= IDLE_S;
      end
    end
  end

  // Motion command toward the servo loop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      motion_cmd <= '0;
    end else begin
      motion_cmd.coast <= !drv_en;
      motion_cmd.target <= target_r;
      if (bipolar) begin
        motion_cmd.accel_group <= GROUP_ONE;
        motion_cmd.torque_mode <= vector_mode && pin_s2_r[4];
        motion_cmd.speed_mode <= !(vector_mode && pin_s2_r[4]);
        motion_cmd.reverse <= bipolar_reference[15];
        motion_cmd.speed <= bipolar_reference;
        // Stop the commanded direction if its enable is gone
        motion_cmd.run <= drv_en && (bipolar_reference[15] ? rev_en : fwd_en);
        if (sel[0]) begin
          motion_cmd.speed <= hspd_r;
          motion_cmd.reverse <= 1'b0;
          motion_cmd.run <= drv_en && fwd_en;
        end
      end else begin
        motion_cmd.torque_mode <= 1'b0;
        motion_cmd.speed_mode <= (state_r == HOME_SEEK_S);
        motion_cmd.reverse <= (state_r != HOME_SEEK_S) && pos_err[31];
        motion_cmd.speed <= move_speed_r;
        motion_cmd.accel_group <= move_group_r;
        motion_cmd.run <= drv_en && (state_r != IDLE_S)
                          && (pos_err[31] ? rev_en : fwd_en);
      end
    end
  end

  // Status: motion indications and table index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_motion <= 1'b0;
      at_position <= 1'b0;
      active_table_index <= 2'h0;
    end else begin
      in_motion <= !bipolar && !near_done;
      if (trig_pulse) begin
        at_position <= 1'b0;
      end else if (!bipolar && near_done && state_r != HOME_SEEK_S) begin
        at_position <= 1'b1;
      end
      if (bipolar && (tbl_sw_ok || !drv_en)) begin
        active_table_index <= sel[3:2];
      end
    end
  end

  // Fault and trip; a new fault wins over a simultaneous reset
  logic fault_rst_d_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_active <= 1'b0;
      ext_trip <= 1'b0;
      fault_rst_d_r <= 1'b0;
    end else begin
      fault_rst_d_r <= grp_in;
      ext_trip <= bipolar && trip_en && !trg_in;
      if (fault_in || (bipolar && trip_en && !trg_in)) begin
        fault_active <= 1'b1;
      end else if ((bipolar && grp_in && !fault_rst_d_r)
                   || (!bipolar && trig_pulse && sel == SEL_RESET)) begin
        fault_active <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence reset_trig_s;
    !bipolar && drv_en && !both_off && trig_pulse && sel == SEL_RESET;
  endsequence
  pos_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    reset_trig_s |=> clear_position) else $error("position reset missed");
  home_group_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == HOME_POS_S |=> motion_cmd.accel_group == GROUP_ONE)
    else $error("offset homing not in group one");
  abort_move_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!bipolar && both_off) |=> state_r == IDLE_S) else $error("move not aborted");
  coast_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !drv_en |=> motion_cmd.coast && !motion_cmd.run) else $error("no coast");
  at_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    trig_pulse |=> !at_position) else $error("at-position not released");
  motion_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!bipolar && !near_done) |=> in_motion) else $error("in-motion missing");
  trig_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
    trig_pulse |=> !trig_pulse) else $error("trigger pulse too long");
  mode_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    drv_en && $past(drv_en) |-> $stable(mode_latch_r)) else $error("mode changed enabled");

endmodule : drive_input_mode_logic
`default_nettype wire

// [hdl/drive_input_pkg.sv]
// Package of constants, register map and types for the drive input-mode logic
package drive_input_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] BAND_OFS = 8'h04;
  localparam logic [7:0] ZSPD_OFS = 8'h08;
  localparam logic [7:0] HOFS_OFS = 8'h0C;
  localparam logic [7:0] POSN_OFS = 8'h10;
  localparam logic [7:0] SPEED_OFS = 8'h14;
  localparam logic [7:0] STAT_OFS = 8'h18;
  localparam logic [7:0] TGT_OFS = 8'h1C;
  localparam logic [7:0] PRESET_OFS = 8'h20;
  localparam logic [7:0] HSPD_OFS = 8'h60;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int CTRL_BIPOLAR_BIT = 0;
  localparam int CTRL_VECTOR_BIT = 1;
  localparam int CTRL_TRIPEN_BIT = 2;
  localparam int CTRL_TBLSW_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h2;

  // ----------------------------------------
  // Position select codes
  // ----------------------------------------
  localparam logic [3:0] SEL_HOME = 4'h0;
  localparam logic [3:0] SEL_ABS_LAST = 4'h6;
  localparam logic [3:0] SEL_RESET = 4'hF;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] BAND_RST = 32'h0000_0010;
  localparam logic [31:0] ZSPD_RST = 32'h0000_0008;
  localparam logic [31:0] HOFS_RST = 32'h0000_0000;
  localparam logic [15:0] HSPD_RST = 16'h0100;
  localparam logic [1:0] GROUP_ONE = 2'h0;
  localparam logic [1:0] GROUP_TWO = 2'h1;

  // Motion command handed to the servo loop
  typedef struct packed {
    logic run;
    logic speed_mode;
    logic torque_mode;
    logic reverse;
    logic coast;
    logic [1:0] accel_group;
    logic [15:0] speed;
    logic [31:0] target;
  } motion_cmd_t;

  typedef enum logic [1:0] {IDLE_S, MOVE_S, HOME_SEEK_S, HOME_POS_S} move_state_t;

endpackage : drive_input_pkg

// [sim/drive_input_mode_logic_tb.sv]
// Self-checking bench for the drive input-mode logic
`timescale 1ns/10ps
`default_nettype none
module drive_input_mode_logic_tb
  import drive_input_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, clr_seen;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, enc, spd;
  logic [3:0] wstrb, sel;
  logic [1:0] bresp, rresp, tbl;
  logic drv_en, fwd_en, rev_en, grp, trig, index_pulse, fault_in;
  logic in_motion, at_position, fault_active, ext_trip, clear_position;
  logic [15:0] bref;
  logic [15:0] amt [16];
  motion_cmd_t cmd;
  int n_fail, num_checks, seed;
  logic [33:0] bus_q[$];
  logic [31:0] pin_q[$];
  int sel_q[$];
  event obs_ev;

  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  drive_input_mode_logic uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .drive_enable_input(drv_en), .forward_enable_input(fwd_en),
    .reverse_enable_input(rev_en), .select_input_a(sel[0]), .select_input_b(sel[1]),
    .select_input_c(sel[2]), .select_input_d(sel[3]), .group_or_reset_input(grp),
    .trigger_or_trip_input(trig), .index_pulse(index_pulse), .fault_in(fault_in),
    .encoder_position(enc), .motor_speed(spd), .bipolar_reference(bref), .motion_cmd(cmd),
    .in_motion(in_motion), .at_position(at_position), .fault_active(fault_active),
    .ext_trip(ext_trip), .clear_position(clear_position), .active_table_index(tbl)
  );

  opto_switch_model sw (
    .aclk(aclk), .drv_en(drv_en), .fwd_en(fwd_en), .rev_en(rev_en), .sel(sel), .grp(grp),
    .trig(trig)
  );

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic cmp_bus(input logic [33:0] e, input logic [33:0] a);
    num_checks++;
    if (a !== e) begin
      n_fail++;
      $display("BAD bus at %0t exp %h got %h", $time, e, a);
    end
  endtask : cmp_bus

  task automatic cmp_pin(input logic [31:0] e, input logic [31:0] a);
    num_checks++;
    if (a !== e) begin
      n_fail++;
      $display("BAD pin at %0t exp %h got %h", $time, e, a);
    end
  endtask : cmp_pin

  function automatic logic [31:0] act(input int s);
    case (s)
      0: return cmd.target;
      1: return {16'h0000, cmd.speed};
      2: return {30'h0000_0000, cmd.accel_group};
      3: return 32'(cmd.run);
      4: return 32'(cmd.speed_mode);
      5: return 32'(cmd.torque_mode);
      6: return 32'(cmd.reverse);
      7: return 32'(cmd.coast);
      8: return 32'(in_motion);
      9: return 32'(at_position);
      10: return 32'(fault_active);
      11: return 32'(ext_trip);
      12: return {30'h0000_0000, tbl};
      13: return 32'(clr_seen);
      default: return {16'h0000, cmd.target[15:0]};
    endcase
  endfunction : act

  // Bus answers are compared in the cycle they are taken
  always @(posedge aclk) begin
    if (bvalid && bready) cmp_bus(bus_q.pop_front(), {bresp, 32'h0000_0000});
    if (rvalid && rready) cmp_bus(bus_q.pop_front(), {rresp, rdata});
    if (clear_position) clr_seen <= 1'b1;
  end

  // Pin notes are compared once the driver says outputs have settled
  always @(obs_ev) begin
    while (pin_q.size() > 0) cmp_pin(pin_q.pop_front(), act(sel_q.pop_front()));
  end

  task automatic chk(input int s, input logic [31:0] e);
    sel_q.push_back(s);
    pin_q.push_back(e);
    ->obs_ev;
  endtask : chk

  // Past the sync chain and output register, then off the edge
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : settle

  // ----------------------------------------
  // Bus and pin drivers
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    bus_q.push_back({r, 32'h0000_0000});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    bus_q.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  // Enables closed, code and group set, then one press
  task automatic go(input logic [3:0] c, input logic g, input int w);
    sw.set_pins(3'b111, c, g, 1'b0);
    sw.press(w);
    settle(8);
  endtask : go

  function automatic logic [31:0] pw(input int i);
    return {16'(i) * 16'h0101, amt[i]};
  endfunction : pw

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // Run needs some 500 cycles (about 2000 ns); far more means a hang
  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, index_pulse, fault_in} = 8'h00;
    {awaddr, araddr, wdata, enc, spd, bref} = '0;
    wstrb = 4'hf;
    clr_seen = 1'b0;
    seed = $urandom(32'h0000_fdf4);
    // Amounts stay well outside the at-position band so a move never ends at once
    for (int i = 0; i < 16; i++) amt[i] = 16'($urandom_range(64, 4095));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    bref <= 16'($urandom_range(256, 32767));
    rd(CTRL_OFS, {30'h0000_0000, CTRL_RST});
    rd(BAND_OFS, {2'b00, BAND_RST});
    rd(ZSPD_OFS, {2'b00, ZSPD_RST});
    rd(HSPD_OFS, {18'h0_0000, HSPD_RST});
    rd(8'h64, {2'b10, 32'h0000_0000});
    wr(8'h64, 32'h1234_5678, 2'b10);
    wr(HOFS_OFS, 32'h0000_0040, 2'b00);
    for (int i = 0; i < 16; i++) wr(PRESET_OFS + 8'(4 * i), pw(i), 2'b00);
    rd(PRESET_OFS + 8'h14, {2'b00, pw(5)});
    $display("register test done");
    // Every absolute and incremental code, group and press width varied
    for (int c = 1; c < 15; c++) begin
      @(posedge aclk);
      enc <= 32'($urandom_range(0, 32767));
      go(4'(c), c[0], 2 + c % 5);
      chk(14, {16'h0000, c < 7 ? amt[c] : 16'(enc[15:0] + amt[c])});
      chk(1, {16'h0000, 16'(c) * 16'h0101});
      chk(2, {30'h0000_0000, c[0] ? GROUP_TWO : GROUP_ONE});
      chk(3, 32'h0000_0001);
    end
    $display("preset move test done");
    @(posedge aclk);
    spd <= 32'h0000_0200;
    go(4'h0, 1'b1, 3);
    chk(4, 32'h0000_0001);
    chk(1, {16'h0000, HSPD_RST});
    chk(2, {30'h0000_0000, GROUP_ONE});
    chk(6, 32'h0000_0000);
    @(posedge aclk);
    enc <= 32'h0000_1000;
    index_pulse <= 1'b1;
    settle(3);
    @(posedge aclk);
    index_pulse <= 1'b0;
    settle(6);
    chk(4, 32'h0000_0000);
    chk(0, 32'h0000_1040);
    chk(1, 32'h0000_0101);
    chk(2, {30'h0000_0000, GROUP_ONE});
    chk(8, 32'h0000_0001);
    @(posedge aclk);
    enc <= 32'h0000_1040;
    spd <= 32'h0000_0000;
    settle(6);
    chk(8, 32'h0000_0000);
    chk(9, 32'h0000_0001);
    go(4'h0, 1'b0, 4);
    chk(9, 32'h0000_0000);
    chk(4, 32'h0000_0001);
    $display("homing test done");
    sw.set_pins(3'b100, 4'h0, 1'b0, 1'b0);
    settle(8);
    chk(3, 32'h0000_0000);
    go(4'h1, 1'b0, 2);
    chk(3, 32'h0000_0001);
    @(posedge aclk);
    fault_in <= 1'b1;
    settle(4);
    chk(10, 32'h0000_0001);
    @(posedge aclk);
    fault_in <= 1'b0;
    clr_seen <= 1'b0;
    go(4'hf, 1'b0, 2);
    chk(10, 32'h0000_0000);
    chk(13, 32'h0000_0001);
    $display("abort and reset test done");
    // Bipolar mode is loaded while the drive is disabled
    sw.set_pins(3'b011, 4'h0, 1'b0, 1'b1);
    wr(CTRL_OFS, 32'h0000_0007, 2'b00);
    for (int t = 0; t < 4; t++) begin
      sw.set_pins(3'b011, {2'(t), 2'b00}, 1'b0, 1'b1);
      settle(8);
      chk(12, 32'(t));
    end
    sw.set_pins(3'b111, 4'b0010, 1'b0, 1'b1);
    settle(8);
    chk(12, 32'h0000_0003);
    chk(5, 32'h0000_0001);
    sw.set_pins(3'b101, 4'b0000, 1'b0, 1'b1);
    settle(8);
    chk(5, 32'h0000_0000);
    chk(3, 32'h0000_0000);
    @(posedge aclk);
    bref <= -bref;
    settle(8);
    chk(3, 32'h0000_0001);
    chk(6, 32'h0000_0001);
    sw.set_pins(3'b111, 4'b0001, 1'b0, 1'b1);
    settle(8);
    chk(4, 32'h0000_0001);
    chk(1, {16'h0000, HSPD_RST});
    @(posedge aclk);
    fault_in <= 1'b1;
    @(posedge aclk);
    fault_in <= 1'b0;
    sw.set_pins(3'b111, 4'h0, 1'b1, 1'b1);
    sw.set_pins(3'b111, 4'h0, 1'b0, 1'b1);
    settle(8);
    chk(10, 32'h0000_0000);
    sw.set_pins(3'b011, 4'h0, 1'b0, 1'b1);
    settle(8);
    chk(7, 32'h0000_0001);
    sw.set_pins(3'b111, 4'h0, 1'b0, 1'b0);
    settle(8);
    chk(11, 32'h0000_0001);
    $display("bipolar test done");
    settle(2);
    print_verdict();
  end
endmodule : drive_input_mode_logic_tb
`default_nettype wire

// [sim/opto_switch_model.sv]
// Switch or controller model that drives the opto inputs
`timescale 1ns/10ps
`default_nettype none
module opto_switch_model (
  input wire logic aclk,
  output logic drv_en,
  output logic fwd_en,
  output logic rev_en,
  output logic [3:0] sel,
  output logic grp,
  output logic trig
);
  // Contacts open at power up
  initial begin
    {drv_en, fwd_en, rev_en} = 3'b000;
    sel = 4'h0;
    grp = 1'b0;
    trig = 1'b0;
  end

  // Levels change just after an edge and then stand
  task automatic set_pins(input logic [2:0] en, input logic [3:0] s, input logic g,
                          input logic t);
    @(posedge aclk);
    {drv_en, fwd_en, rev_en} <= en;
    sel <= s;
    grp <= g;
    trig <= t;
  endtask : set_pins

  // Momentary closure; a slow press holds it for many cycles
  task automatic press(input int width);
    @(posedge aclk);
    trig <= 1'b1;
    repeat (width) @(posedge aclk);
    trig <= 1'b0;
  endtask : press
endmodule : opto_switch_model
`default_nettype wire
